// ===== logic/cfg_pkg.sv
package cfg_pkg;

  // Register offsets on the serial configuration port
  localparam logic [7:0] ADDR_DEV_ID     = 8'h00;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h01;
  localparam logic [7:0] ADDR_PIN0_CFG   = 8'h02;
  localparam logic [7:0] ADDR_PIN1_CFG   = 8'h03;
  localparam logic [7:0] ADDR_PIN2_CFG   = 8'h04;
  localparam logic [7:0] ADDR_GP_IN      = 8'h05;
  localparam logic [7:0] ADDR_OUT_VAL    = 8'h06;

  // Field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int MODE_MSB       = 7;
  localparam int MODE_LSB       = 4;
  localparam int PULL_MSB       = 3;
  localparam int PULL_LSB       = 2;
  localparam int IN_EN_BIT      = 1;
  localparam int OUT_EN_BIT     = 0;
  localparam int NUM_PINS       = 3;

  // Reset values
  localparam logic [6:0] DEV_ADDR_RST   = 7'h58;
  localparam logic [7:0] PIN_CFG_RST    = 8'h05;
  localparam logic [2:0] OUT_VAL_RST    = 3'h0;
  localparam logic       SOFT_RESET_RST = 1'h0;

  // Pull field codes
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP   = 2'h2;

  // Function codes, one source per code
  localparam logic [3:0] MODE_P0_OUT_BIT = 4'h0;
  localparam logic [3:0] MODE_P0_SIG_DET = 4'h1;
  localparam logic [3:0] MODE_P1_POR     = 4'h0;
  localparam logic [3:0] MODE_P1_OUT_BIT = 4'h1;
  localparam logic [3:0] MODE_P1_SIG_DET = 4'h2;
  localparam logic [3:0] MODE_P1_LOCK    = 4'h3;
  localparam logic [3:0] MODE_P2_OUT_BIT = 4'h0;
  localparam logic [3:0] MODE_P2_AON_CLK = 4'h1;
  localparam logic [3:0] MODE_P2_TX_CLK  = 4'h2;
  localparam logic [3:0] MODE_P2_CDR_CLK = 4'h3;

  // One pin configuration byte, laid out as in the register
  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] pull;
    logic       in_en;
    logic       out_en;
  } pin_cfg_t;

  // Register write request from the serial engine
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_t;

  // Serial engine states, Gray coded in the order listed
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_CMD   = 3'h3,
    ST_WDATA = 3'h2,
    ST_ACK   = 3'h6,
    ST_READ  = 3'h7,
    ST_RACK  = 3'h5
  } smb_state_t;

endpackage : cfg_pkg

// ===== logic/sync_2ff.sv
`timescale 1ns/1ns
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // Two stages; the first one feeds nothing but the second
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : sync_2ff

// ===== logic/pin_cell.sv
`timescale 1ns/1ns
module pin_cell (
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  input  wire cfg_pkg::pin_cfg_t cfg_i,
  input  wire logic [3:0]        src_i,
  input  wire logic [3:0]        clk_src_i,
  input  wire logic [3:0]        clk_mask_i,
  output logic                   pad_out_o,
  output logic                   pad_oe_n_o,
  output logic                   pull_up_o,
  output logic                   pull_down_o,
  output logic                   input_en_o
);
  import cfg_pkg::*;

  logic       data_q;
  logic       legal_w;
  logic       clk_mode_w;
  logic [1:0] sel_w;

  // Codes above 3 are reserved and drive a steady low
  assign legal_w    = (cfg_i.mode[3:2] == 2'h0);
  assign sel_w      = cfg_i.mode[1:0];
  assign clk_mode_w = legal_w && clk_mask_i[sel_w];

  // Data sources are retimed; forwarded clocks cannot be
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_q      <= 1'b0;
      pad_oe_n_o  <= 1'b0;
      pull_up_o   <= 1'b0;
      pull_down_o <= 1'b1;
      input_en_o  <= 1'b0;
    end else begin
      data_q      <= legal_w && src_i[sel_w];
      pad_oe_n_o  <= ~cfg_i.out_en;
      pull_up_o   <= (cfg_i.pull == PULL_UP);
      pull_down_o <= (cfg_i.pull == PULL_DOWN);
      input_en_o  <= cfg_i.in_en;
    end
  end

  // Clock modes bypass the flop; a switch may leave one short pulse
  assign pad_out_o = clk_mode_w ? clk_src_i[sel_w] : data_q;

endmodule : pin_cell

// ===== logic/soft_reset_and_pin_config.sv
//////////////////////////////////////////////////////////////////////////////
// Operation
// - Writing one to soft-reset bit returns pin config and output registers to power-up values.
// - Soft reset keeps the device address register as last written.
// - Pin 0 function: 0 general output bit, 1 signal detect 0.
// - Pin 1 function: reset flag, output bit, detect 1, lock.
// - Pin 2 function: output bit, free clock, transmit clock, CDR clock.
// - Pull field: 00 none, 01 pulldown, 10 pullup; default pulldown.
// - Bit 1 enables the pin input buffer; default disabled.
// - Bit 0 enables the pin output driver; default enabled.
// - General output register bits 2 to 0 reach pins in output mode.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module soft_reset_and_pin_config (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       smb_scl_i,
  input  wire logic       smb_sda_i,
  output logic            smb_sda_o,
  output logic            smb_sda_oe_n_o,
  input  wire logic       smb_sel_i,
  input  wire logic [1:0] sig_detect_i,
  input  wire logic       cdr_lock_i,
  input  wire logic       always_on_clk_i,
  input  wire logic       lvds_tx_clk_i,
  input  wire logic       cdr_clk_i,
  input  wire logic [2:0] pad_in_i,
  output logic      [2:0] pad_out_o,
  output logic      [2:0] pad_oe_n_o,
  output logic      [2:0] pull_up_o,
  output logic      [2:0] pull_down_o,
  output logic      [2:0] input_en_o
);
  import cfg_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  logic       scl_s;
  logic       sda_s;
  logic       sel_s;
  logic [1:0] sig_det_s;
  logic       lock_s;
  logic [2:0] pad_in_s;
  logic       scl_prev_q;
  logic       sda_prev_q;

  logic       start_w;
  logic       stop_w;
  logic       rise_w;
  logic       fall_w;
  logic       rx_state_w;
  logic       byte_done_w;
  logic       addr_match_w;

  smb_state_t state_q;
  smb_state_t next_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  reg_req_t   req_q;

  logic [6:0] dev_addr_q;
  logic       soft_trig_q;
  logic [2:0] out_val_q;
  logic       por_done_q;
  pin_cfg_t   pin_cfg_q [NUM_PINS];
  logic [2:0] gp_in_w;
  logic [7:0] rd_data_w;

  logic [3:0] src_w      [NUM_PINS];
  logic [3:0] clk_src_w  [NUM_PINS];
  logic [3:0] clk_mask_w [NUM_PINS];

  // True when a write request targets the given offset
  function automatic logic hit(input reg_req_t req, input logic [7:0] addr);
    hit = req.wr && (req.addr == addr);
  endfunction : hit

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  // Every pin and foreign-domain flag except the three forwarded clocks is retimed before use
  sync_2ff #(
    .WIDTH (9)
  ) u_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .async_i ({smb_scl_i, smb_sda_i, smb_sel_i, sig_detect_i, cdr_lock_i,
               pad_in_i}),
    .sync_o  ({scl_s, sda_s, sel_s, sig_det_s, lock_s, pad_in_s})
  );

  // History resets low like the synchroniser, so no false fall or
  // stop follows reset; the first rise lands in idle and is ignored
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_prev_q <= 1'b0;
      sda_prev_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // Bus conditions seen on the retimed lines
  assign start_w = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_w  = scl_s && scl_prev_q && !sda_prev_q && sda_s;
  assign rise_w  = scl_s && !scl_prev_q;
  assign fall_w  = !scl_s && scl_prev_q;

  assign rx_state_w   = (state_q == ST_ADDR) || (state_q == ST_CMD) ||
                        (state_q == ST_WDATA);
  assign byte_done_w  = (cnt_q == 4'h8);
  // Address byte is compared without its direction bit
  assign addr_match_w = sel_s && (shift_q[7:1] == dev_addr_q);

  //////////////////////////////////////////////////////////////////////////
  // Serial byte engine

  // Start and stop win over any bit activity; the SDA driver only
  // changes while SCL is low, so it never forges a start or stop
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q   <= ST_IDLE;
      next_q    <= ST_IDLE;
      cnt_q     <= 4'h0;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      smb_sda_oe_n_o <= 1'b1;
      req_q     <= '0;
    end else begin
      req_q.wr <= 1'b0;
      if (start_w) begin
        state_q        <= ST_ADDR;
        cnt_q          <= 4'h0;
        smb_sda_oe_n_o <= 1'b1;
      end else if (stop_w) begin
        state_q        <= ST_IDLE;
        smb_sda_oe_n_o <= 1'b1;
      end else if (rise_w) begin
        if (rx_state_w) begin
          shift_q <= {shift_q[6:0], sda_s};
          cnt_q   <= cnt_q + 4'h1;
        end else if (state_q == ST_READ) begin
          cnt_q <= cnt_q + 4'h1;
        end else if (state_q == ST_RACK) begin
          // Master acknowledge asks for the next register
          if (!sda_s) begin
            ptr_q   <= ptr_q + 8'h01;
            state_q <= ST_ACK;
            next_q  <= ST_READ;
          end else begin
            state_q <= ST_IDLE;
          end
        end
      end else if (fall_w) begin
        if (rx_state_w && byte_done_w) begin
          cnt_q <= 4'h0;
          unique case (state_q)
            ST_ADDR: begin
              if (addr_match_w) begin
                smb_sda_oe_n_o <= 1'b0;
                state_q        <= ST_ACK;
                next_q         <= shift_q[0] ? ST_READ : ST_CMD;
              end else begin
                state_q <= ST_IDLE;
              end
            end
            ST_CMD: begin
              ptr_q          <= shift_q;
              smb_sda_oe_n_o <= 1'b0;
              state_q        <= ST_ACK;
              next_q         <= ST_WDATA;
            end
            ST_WDATA: begin
              req_q.wr       <= 1'b1;
              req_q.addr     <= ptr_q;
              req_q.data     <= shift_q;
              ptr_q          <= ptr_q + 8'h01;
              smb_sda_oe_n_o <= 1'b0;
              state_q        <= ST_ACK;
              next_q         <= ST_WDATA;
            end
            default: state_q <= ST_IDLE;
          endcase
        end else if (state_q == ST_ACK) begin
          cnt_q   <= 4'h0;
          state_q <= next_q;
          if (next_q == ST_READ) begin
            shift_q        <= rd_data_w;
            smb_sda_oe_n_o <= rd_data_w[7];
          end else begin
            smb_sda_oe_n_o <= 1'b1;
          end
        end else if (state_q == ST_READ) begin
          if (byte_done_w) begin
            smb_sda_oe_n_o <= 1'b1;
            state_q        <= ST_RACK;
          end else begin
            shift_q        <= {shift_q[6:0], 1'b0};
            smb_sda_oe_n_o <= shift_q[6];
          end
        end
      end
    end
  end

  // Open-drain line: only ever pulled low
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      smb_sda_o <= 1'b0;
    end else begin
      smb_sda_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  // Power-up flag: low in reset, high from the first edge after it
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      por_done_q <= 1'b0;
    end else begin
      por_done_q <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dev_addr_q <= DEV_ADDR_RST;
    end else if (hit(req_q, ADDR_DEV_ID)) begin
      dev_addr_q <= req_q.data[7:1];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      soft_trig_q <= SOFT_RESET_RST;
    end else if (soft_trig_q) begin
      soft_trig_q <= SOFT_RESET_RST;
    end else if (hit(req_q, ADDR_SOFT_RESET)) begin
      soft_trig_q <= req_q.data[SOFT_RESET_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_val_q <= OUT_VAL_RST;
    end else if (soft_trig_q) begin
      out_val_q <= OUT_VAL_RST;
    end else if (hit(req_q, ADDR_OUT_VAL)) begin
      out_val_q <= req_q.data[2:0];
    end
  end

  // Pin configuration bytes, one per pin
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_cfg
    always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
        pin_cfg_q[i] <= pin_cfg_t'(PIN_CFG_RST);
      end else if (soft_trig_q) begin
        pin_cfg_q[i] <= pin_cfg_t'(PIN_CFG_RST);
      end else if (hit(req_q, ADDR_PIN0_CFG + 8'(i))) begin
        pin_cfg_q[i] <= pin_cfg_t'(req_q.data);
      end
    end
    assign gp_in_w[i] = pad_in_s[i] && pin_cfg_q[i].in_en;
  end

  // Read selection; reserved bits and unmapped offsets read zero
  assign rd_data_w =
    (ptr_q == ADDR_DEV_ID)     ? {dev_addr_q, 1'b0} :
    (ptr_q == ADDR_SOFT_RESET) ? {7'h00, soft_trig_q} :
    (ptr_q == ADDR_PIN0_CFG)   ? 8'(pin_cfg_q[0]) :
    (ptr_q == ADDR_PIN1_CFG)   ? 8'(pin_cfg_q[1]) :
    (ptr_q == ADDR_PIN2_CFG)   ? 8'(pin_cfg_q[2]) :
    (ptr_q == ADDR_GP_IN)      ? {5'h00, gp_in_w} :
    (ptr_q == ADDR_OUT_VAL)    ? {5'h00, out_val_q} : 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Pin sources

  assign src_w[0]      = {2'h0, sig_det_s[0], out_val_q[0]};
  assign clk_src_w[0]  = 4'h0;
  assign clk_mask_w[0] = 4'h0;
  assign src_w[1]      = {lock_s, sig_det_s[1], out_val_q[1], por_done_q};
  assign clk_src_w[1]  = 4'h0;
  assign clk_mask_w[1] = 4'h0;
  assign src_w[2]      = {3'h0, out_val_q[2]};
  assign clk_src_w[2]  = {cdr_clk_i, lvds_tx_clk_i, always_on_clk_i, 1'b0};
  assign clk_mask_w[2] = 4'hE;

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    pin_cell u_cell (
      .clock_i     (clock_i),
      .rstn_i      (rstn_i),
      .cfg_i       (pin_cfg_q[i]),
      .src_i       (src_w[i]),
      .clk_src_i   (clk_src_w[i]),
      .clk_mask_i  (clk_mask_w[i]),
      .pad_out_o   (pad_out_o[i]),
      .pad_oe_n_o  (pad_oe_n_o[i]),
      .pull_up_o   (pull_up_o[i]),
      .pull_down_o (pull_down_o[i]),
      .input_en_o  (input_en_o[i])
    );
  end

endmodule : soft_reset_and_pin_config

// ===== verif/smb_host.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Bus host model: owns the serial clock, pulls data low or lets it go
module smb_host (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // Idle bus: clock high, data left to its pull-up
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic ph(input int n);
    repeat (n) @(negedge clock_i);
  endtask : ph
  // Data moves a few clocks after the fall, so the synced pins never
  // see clock and data change together and fake a start or stop
  task automatic bit_x(input logic b, output logic r);
    ph(3);
    sda_low_o = ~b;
    ph(7);
    scl_o = 1'b1;
    ph(10);
    r     = sda_i;
    scl_o = 1'b0;
  endtask : bit_x
  // Start, also used as repeated start
  task automatic start();
    ph(3);
    sda_low_o = 1'b0;
    ph(7);
    scl_o = 1'b1;
    ph(10);
    sda_low_o = 1'b1;
    ph(10);
    scl_o = 1'b0;
  endtask : start
  task automatic stop();
    ph(3);
    sda_low_o = 1'b1;
    ph(7);
    scl_o = 1'b1;
    ph(10);
    sda_low_o = 1'b0;
    ph(10);
  endtask : stop
  // Eight bits MSB first, then the acknowledge slot with data released
  task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx,
                        output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask : byte_x
  task automatic wr(input logic [7:0] dev, input logic [7:0] a,
                    input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       k0, k1, k2;
    start();
    byte_x(dev, rx, k0);
    byte_x(a, rx, k1);
    byte_x(d, rx, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask : wr
  // Read ends with a not-acknowledge from the host, then stop
  task automatic rd(input logic [7:0] dev, input logic [7:0] a,
                    output logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       k0, k1, k2, kn;
    start();
    byte_x(dev, rx, k0);
    byte_x(a, rx, k1);
    start();
    byte_x(dev | 8'h01, rx, k2);
    byte_x(8'hFF, d, kn);
    stop();
    ok = k0 & k1 & k2;
  endtask : rd
endmodule : smb_host

// ===== verif/soft_reset_and_pin_config_checker.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module soft_reset_and_pin_config_checker (
  input wire logic       clock_i,
  input wire logic       rstn_i,
  input wire logic       smb_scl_i,
  input wire logic [2:0] pad_out_o,
  input wire logic [2:0] pad_oe_n_o,
  input wire logic [2:0] pull_up_o,
  input wire logic [2:0] pull_down_o,
  input wire logic [2:0] input_en_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Even the reserved pull code must never turn both resistors on
  property p_pull_excl;
    (pull_up_o & pull_down_o) == 3'h0;
  endproperty
  a_pull_excl: assert property (p_pull_excl)
    else $error("pull-up and pull-down both on");
  property p_rst_pull;
    $rose(rstn_i) |-> pull_down_o == 3'h7 && pull_up_o == 3'h0;
  endproperty
  a_rst_pull: assert property (p_rst_pull)
    else $error("pull defaults wrong after reset");
  property p_rst_inen;
    $rose(rstn_i) |-> input_en_o == 3'h0;
  endproperty
  a_rst_inen: assert property (p_rst_inen)
    else $error("input buffers on after reset");
  property p_rst_oe;
    $rose(rstn_i) |-> pad_oe_n_o == 3'h0;
  endproperty
  a_rst_oe: assert property (p_rst_oe)
    else $error("drivers off after reset");
  property p_por_pin;
    $rose(rstn_i) |-> !pad_out_o[1] ##[1:3] pad_out_o[1];
  endproperty
  a_por_pin: assert property (p_por_pin)
    else $error("pin 1 power-on flag missing");
  // Config writes land early in the low clock phase, never with it high
  property p_inen_scl;
    $changed(input_en_o) && $past(rstn_i) |-> !smb_scl_i;
  endproperty
  a_inen_scl: assert property (p_inen_scl)
    else $error("input enable moved outside a write");
  property p_oe_scl;
    $changed(pad_oe_n_o) && $past(rstn_i) |-> !smb_scl_i;
  endproperty
  a_oe_scl: assert property (p_oe_scl)
    else $error("driver enable moved outside a write");
  property p_pull_hold;
    smb_scl_i [*4] |-> $stable(pull_up_o) && $stable(pull_down_o);
  endproperty
  a_pull_hold: assert property (p_pull_hold)
    else $error("pull changed while bus clock high");
endmodule : soft_reset_and_pin_config_checker

bind soft_reset_and_pin_config soft_reset_and_pin_config_checker
  i_soft_reset_and_pin_config_checker (
  .clock_i, .rstn_i, .smb_scl_i, .pad_out_o, .pad_oe_n_o, .pull_up_o,
  .pull_down_o, .input_en_o);

// ===== verif/soft_reset_and_pin_config_tb_top.sv
`timescale 1ns/1ns
module soft_reset_and_pin_config_tb_top;
  import cfg_pkg::*;
  logic       clock_i, rstn_i, sel, aon, txc, cdrc, lock;
  logic [1:0] sig;
  logic [2:0] pad_in;
  wire        scl, host_low, sda, sda_o, sda_oe_n;
  wire  [2:0] pad_out, pad_oe_n, pull_up, pull_down, input_en;
  logic [7:0] dev = 8'hB0;
  int         bad_count = 0;
  int         checked = 0;
  // Open-drain data line with pull-up
  assign sda = ~(host_low | (~sda_oe_n & ~sda_o));
  smb_host i_smb_host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(host_low));
  soft_reset_and_pin_config i_soft_reset_and_pin_config (
    .clock_i(clock_i), .rstn_i(rstn_i), .smb_scl_i(scl), .smb_sda_i(sda),
    .smb_sda_o(sda_o), .smb_sda_oe_n_o(sda_oe_n), .smb_sel_i(sel),
    .sig_detect_i(sig), .cdr_lock_i(lock), .always_on_clk_i(aon),
    .lvds_tx_clk_i(txc), .cdr_clk_i(cdrc), .pad_in_i(pad_in),
    .pad_out_o(pad_out), .pad_oe_n_o(pad_oe_n), .pull_up_o(pull_up),
    .pull_down_o(pull_down), .input_en_o(input_en));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    i_smb_host.wr(dev, a, d, ok);
    check({7'h00, ok}, 8'h01);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    logic       ok;
    logic [7:0] d;
    i_smb_host.rd(dev, a, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
  endtask : rreg
  //////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    logic ok;
    check({5'h00, pad_out}, 8'h02);
    check({5'h00, pad_oe_n}, 8'h00);
    check({2'h0, pull_up, pull_down}, 8'h07);
    check({5'h00, input_en}, 8'h00);
    rreg(ADDR_SOFT_RESET, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rreg(ADDR_PIN0_CFG + 8'(i), 8'h05);
    end
    rreg(8'h07, 8'h00);
    // Deselected device must ignore the write
    @(negedge clock_i);
    sel = 1'b0;
    i_smb_host.wr(dev, ADDR_PIN0_CFG, 8'hFF, ok);
    sel = 1'b1;
    check({7'h00, ok}, 8'h00);
    rreg(ADDR_PIN0_CFG, 8'h05);
  endtask : t_defaults
  // Codes 0 to n-1 of a pin's function field under two opposite stimuli
  task automatic sweep(input logic [7:0] a, input int p, input int n,
                       input logic [3:0] ea, input logic [3:0] eb);
    for (int k = 0; k < n; k++) begin
      wreg(a, {k[3:0], 4'h5});
      wreg(ADDR_OUT_VAL, 8'h07);
      @(negedge clock_i);
      {lock, sig} = 3'h0;
      repeat (5) @(negedge clock_i);
      check({7'h00, pad_out[p]}, {7'h00, ea[k]});
      wreg(ADDR_OUT_VAL, 8'h00);
      {lock, sig} = 3'h7;
      repeat (5) @(negedge clock_i);
      check({7'h00, pad_out[p]}, {7'h00, eb[k]});
    end
  endtask : sweep
  task automatic t_pads();
    for (int p = 0; p < 4; p++) begin
      // input use: driver off, buffer on
      wreg(ADDR_PIN2_CFG, {4'h0, p[1:0], 2'b10});
      rreg(ADDR_PIN2_CFG, {4'h0, p[1:0], 2'b10});
      check({7'h00, pull_up[2]}, {7'h00, p == 2});
      check({7'h00, pull_down[2]}, {7'h00, p == 1});
      check({6'h00, input_en[2], pad_oe_n[2]}, 8'h03);
    end
    // Only pin 2 has its input buffer on, so only its level reads back
    pad_in = 3'h7;
    rreg(ADDR_GP_IN, 8'h04);
    pad_in = 3'h0;
    // output use: buffer off, driver on
    wreg(ADDR_PIN2_CFG, 8'h01);
    check({6'h00, input_en[2], pad_oe_n[2]}, 8'h00);
  endtask : t_pads
  // Clock sources reach pin 2 without retiming
  task automatic t_clocks();
    logic [2:0] one;
    wreg(ADDR_OUT_VAL, 8'h04);
    for (int k = 0; k < 4; k++) begin
      wreg(ADDR_PIN2_CFG, {k[3:0], 4'h5});
      one = (k == 0) ? 3'h0 : 3'h1 << (k - 1);
      {cdrc, txc, aon} = one;
      #1 check({7'h00, pad_out[2]}, 8'h01);
      @(negedge clock_i);
      {cdrc, txc, aon} = ~one;
      #1 check({7'h00, pad_out[2]}, {7'h00, k == 0});
      @(negedge clock_i);
      {cdrc, txc, aon} = 3'h0;
    end
  endtask : t_clocks
  task automatic t_soft();
    logic ok;
    // Pin 0 as input with pull-up, so every pad control must move back
    wreg(ADDR_PIN0_CFG, 8'hAA);
    wreg(ADDR_OUT_VAL, 8'h07);
    wreg(ADDR_DEV_ID, 8'hC2);
    i_smb_host.wr(8'hB0, ADDR_OUT_VAL, 8'h00, ok);
    check({7'h00, ok}, 8'h00);
    dev = 8'hC2;
    wreg(ADDR_SOFT_RESET, 8'h01);
    rreg(ADDR_SOFT_RESET, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rreg(ADDR_PIN0_CFG + 8'(i), 8'h05);
    end
    rreg(ADDR_OUT_VAL, 8'h00);
    rreg(ADDR_DEV_ID, 8'hC2);
    check({2'h0, pull_up, pull_down}, 8'h07);
    check({5'h00, pad_oe_n}, 8'h00);
    check({5'h00, input_en}, 8'h00);
    wreg(ADDR_DEV_ID, 8'hB0);
    dev = 8'hB0;
  endtask : t_soft
  //////////////////////////////////////////////////////////////////////////
  // Free-running 20 MHz register clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // Main sequence
  initial begin
    rstn_i = 1'b0;
    sel    = 1'b1;
    {cdrc, txc, aon, lock, sig, pad_in} = 8'h00;
    repeat (16) @(negedge clock_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clock_i);
    t_defaults();
    $display("test defaults done");
    sweep(ADDR_PIN0_CFG, 0, 3, 4'b0001, 4'b0010);
    sweep(ADDR_PIN1_CFG, 1, 4, 4'b0011, 4'b1101);
    $display("test sources done");
    t_pads();
    $display("test pads done");
    t_clocks();
    $display("test clocks done");
    t_soft();
    $display("test soft reset done");
    results();
  end
  // Whole run is near 36000 cycles; stop well past that
  initial begin
    repeat (70000) @(posedge clock_i);
    bad_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    results();
  end
endmodule : soft_reset_and_pin_config_tb_top
